// ===== src/liu_regs_pkg.sv
// Package: register map, field positions and timing for the line-interface register bank
`default_nettype none
package liu_regs_pkg;
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets on the parallel port
    localparam logic [3:0] GLOBAL_COMMAND_ONE_ADDR = 4'h0;
    localparam logic [3:0] GLOBAL_COMMAND_TWO_ADDR = 4'h1;
    localparam logic [3:0] CHANNEL0_ALARM_STATUS_ADDR = 4'h2;
    localparam logic [3:0] CHANNEL1_ALARM_STATUS_ADDR = 4'h5;
    localparam logic [3:0] CHANNEL2_ALARM_STATUS_ADDR = 4'h8;
    localparam logic [3:0] CHANNEL3_ALARM_STATUS_ADDR = 4'hb;
    localparam logic [3:0] ALARM_ENABLE_BASE_ADDR = 4'h3;
    localparam logic [3:0] CHANNEL_STRIDE = 4'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    // global_command_two fields
    localparam int FIFO_DEPTH_BIT = 5;
    localparam int RX_JA_BIT = 4;
    localparam int TX_JA_BIT = 3;
    localparam int RX_SQUELCH_BIT = 2;
    localparam int EXT_LOSS_BIT = 1;
    localparam int BOARD_TEST_BIT = 0;
    localparam logic [7:0] COMMAND_TWO_WRITE_MASK = 8'h3f;
    // global_command_one field
    localparam int GLOBAL_IRQ_BIT = 1;
    // Status fields: live in [7:4], latched changes in [3:0]
    localparam int LIVE_LSB = 4;
    localparam int CHANGED_LSB = 0;
    // Elastic buffer depths in bits
    localparam int FIFO_DEPTH_SHORT = 32;
    localparam int FIFO_DEPTH_LONG = 64;
    // Zero-run lengths before loss of signal is declared
    localparam int LOSS_ZEROS_NORMAL = 32;
    localparam int LOSS_ZEROS_EXTENDED = 4096;
    localparam int LOSS_CNT_W = 13;

    typedef enum logic [1:0] {JA_OFF, JA_TX, JA_RX} ja_place_t;

    // Live alarms of one channel, in status bit order (driver, loss, violation, clock)
    typedef struct packed {
        logic driver_fault_now;
        logic signal_loss_now;
        logic code_violation_now;
        logic tx_clock_missing_now;
    } alarm_live_t;

    // Datapath controls decoded from global_command_two
    typedef struct packed {
        logic [6:0] fifo_depth;
        ja_place_t ja_place;
        logic rx_squelch_on_signal_loss;
        logic extended_loss_window;
        logic board_test_tristate;
    } datapath_ctrl_t;
endpackage : liu_regs_pkg
`default_nettype wire

// ===== src/alarm_channel.sv
// One channel's alarm status: live bits, clear-on-read change latches, loss detector
`default_nettype none
module alarm_channel #(
    parameter int ZERO_RUN_LONG = liu_regs_pkg::LOSS_ZEROS_EXTENDED
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Line sampling: one received bit per strobe, already in clk domain
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic extended_loss_window,
    // Other alarms from the datapath, already synchronised
    input wire logic driver_fault_in,
    input wire logic code_violation_in,
    input wire logic tx_clock_missing_in,
    // Register side
    input wire logic status_read,
    input wire logic [3:0] alarm_enable,
    output logic [7:0] status,
    output logic signal_loss,
    output logic irq_pending
);
    logic [liu_regs_pkg::LOSS_CNT_W-1:0] zero_run_q;
    logic [liu_regs_pkg::LOSS_CNT_W-1:0] loss_limit;
    liu_regs_pkg::alarm_live_t live_q;
    liu_regs_pkg::alarm_live_t live_d;
    logic [3:0] changed_q;
    logic [3:0] toggled;
    logic loss_q;

    ////////////////////////////////////////////////////////////////////////
    // Loss of signal from the run of consecutive zeros
    assign loss_limit = extended_loss_window
        ? liu_regs_pkg::LOSS_CNT_W'(ZERO_RUN_LONG)
        : liu_regs_pkg::LOSS_CNT_W'(liu_regs_pkg::LOSS_ZEROS_NORMAL);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            zero_run_q <= '0;
            loss_q <= 1'b0;
        end
        else if (rx_bit_valid)
        begin
            if (rx_bit)
            begin
                zero_run_q <= '0;
                loss_q <= 1'b0;
            end
            else
            begin
                // Saturate so a long dead line never wraps back to no-loss
                if (zero_run_q < loss_limit)
                    zero_run_q <= zero_run_q + 1'b1;
                loss_q <= (zero_run_q + 1'b1) >= loss_limit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Live bits and change latches
    assign live_d = '{driver_fault_in, loss_q, code_violation_in, tx_clock_missing_in};
    assign toggled = live_d ^ live_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            live_q <= '0;
        else
            live_q <= live_d;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            changed_q <= '0;
        else
            // A change arriving with the read survives: set beats clear
            changed_q <= (status_read ? 4'h0 : changed_q) | toggled;
    end

    assign status = {live_q, changed_q};
    assign signal_loss = live_q.signal_loss_now;
    assign irq_pending = |(changed_q & alarm_enable);
endmodule : alarm_channel
`default_nettype wire

// ===== src/e1_liu_config_status_regs.sv
// Register bank: global commands, per-channel alarm status and mask, datapath controls
`default_nettype none
// Operation
// - fifo_depth_select one gives 64-bit elastic buffer, zero gives 32.
// - tx_jitter_atten_select alone puts the attenuator in transmit path.
// - rx select alone puts it in receive path; both set bypasses it.
// - Squelch forces receive data low while loss of signal persists.
// - Extended window declares loss only after 4096 consecutive zeros.
// - board_test_tristate floats every output, same as test pin low.
// - Status registers decode at 0010, 0101, 1000, 1011 for channels 0-3.
// - Bit 7 shows live driver fault; reads leave it.
// - Bit 6 shows live signal loss; reads leave it.
// - Bit 5 shows live code violation; reads leave it.
// - Bit 4 shows live transmit clock absence; reads leave it.
// - Any edge of any live alarm raises a channel event.
// - Bits 3 to 0 latch one when their live alarm changes.
// - Reading status returns latched bits then clears them; live bits stay.
// - No interrupt while global_irq_enable is zero.
// - An alarm change interrupts only if its enable bit is one.
module e1_liu_config_status_regs #(
    parameter int ZERO_RUN_LONG = liu_regs_pkg::LOSS_ZEROS_EXTENDED,
    parameter int NUM_CH = liu_regs_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Parallel register port, synchronous to clk
    input wire logic [liu_regs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [liu_regs_pkg::DATA_W-1:0] reg_wdata,
    output logic [liu_regs_pkg::DATA_W-1:0] reg_rdata,
    // Hardware test pin, active low, asynchronous
    input wire logic board_test_n,
    // Per-channel line inputs from the receiver
    input wire logic [NUM_CH-1:0] rx_bit_valid,
    input wire logic [NUM_CH-1:0] rx_bit,
    // Per-channel alarm sources, asynchronous
    input wire logic [NUM_CH-1:0] driver_fault_in,
    input wire logic [NUM_CH-1:0] code_violation_in,
    input wire logic [NUM_CH-1:0] tx_clock_missing_in,
    // Receive data to mute
    input wire logic [NUM_CH-1:0] rx_data_in,
    output logic [NUM_CH-1:0] rx_data_out,
    // Datapath controls
    output liu_regs_pkg::datapath_ctrl_t datapath_ctrl,
    output logic outputs_float_n,
    // Interrupt, open drain: enable low while pulling the line low
    output logic irq_out,
    output logic irq_oe_n
);
    logic [7:0] command_one_q;
    logic [7:0] command_two_q;
    logic [3:0] alarm_enable_q [NUM_CH];
    logic [NUM_CH-1:0] status_read;
    logic [7:0] status [NUM_CH];
    logic [NUM_CH-1:0] signal_loss;
    logic [NUM_CH-1:0] pending;
    logic [3*NUM_CH-1:0] alarm_meta_q;
    logic [3*NUM_CH-1:0] alarm_sync_q;
    logic [1:0] test_pin_q;
    logic [7:0] rdata_d;
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers for alarm and test pins
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alarm_meta_q <= '0;
            alarm_sync_q <= '0;
            test_pin_q <= 2'b11;
        end
        else
        begin
            alarm_meta_q <= {tx_clock_missing_in, code_violation_in, driver_fault_in};
            alarm_sync_q <= alarm_meta_q;
            test_pin_q <= {test_pin_q[0], board_test_n};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Global command registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            command_one_q <= liu_regs_pkg::REG_RESET;
        else if (reg_write && reg_addr == liu_regs_pkg::GLOBAL_COMMAND_ONE_ADDR)
            command_one_q <= reg_wdata;
    end

    // Stored as written; upper bits have no effect here, the host keeps them zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            command_two_q <= liu_regs_pkg::REG_RESET;
        else if (reg_write && reg_addr == liu_regs_pkg::GLOBAL_COMMAND_TWO_ADDR)
            command_two_q <= reg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath control decode
    always_comb
    begin
        datapath_ctrl.fifo_depth = command_two_q[liu_regs_pkg::FIFO_DEPTH_BIT]
            ? 7'(liu_regs_pkg::FIFO_DEPTH_LONG)
            : 7'(liu_regs_pkg::FIFO_DEPTH_SHORT);
        case ({command_two_q[liu_regs_pkg::RX_JA_BIT], command_two_q[liu_regs_pkg::TX_JA_BIT]})
            2'b01: datapath_ctrl.ja_place = liu_regs_pkg::JA_TX;
            2'b10: datapath_ctrl.ja_place = liu_regs_pkg::JA_RX;
            default: datapath_ctrl.ja_place = liu_regs_pkg::JA_OFF;
        endcase
        datapath_ctrl.rx_squelch_on_signal_loss = command_two_q[liu_regs_pkg::RX_SQUELCH_BIT];
        datapath_ctrl.extended_loss_window = command_two_q[liu_regs_pkg::EXT_LOSS_BIT];
        datapath_ctrl.board_test_tristate = command_two_q[liu_regs_pkg::BOARD_TEST_BIT];
    end

    // Software bit and the pin act the same way
    assign outputs_float_n = !(command_two_q[liu_regs_pkg::BOARD_TEST_BIT]
        || !test_pin_q[1]);

    ////////////////////////////////////////////////////////////////////////
    // Per-channel status, enables and muting
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            localparam logic [3:0] STATUS_ADDR =
                liu_regs_pkg::CHANNEL0_ALARM_STATUS_ADDR + 4'(ch) * liu_regs_pkg::CHANNEL_STRIDE;
            localparam logic [3:0] ENABLE_ADDR =
                liu_regs_pkg::ALARM_ENABLE_BASE_ADDR + 4'(ch) * liu_regs_pkg::CHANNEL_STRIDE;

            assign status_read[ch] = reg_read && reg_addr == STATUS_ADDR;

            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    alarm_enable_q[ch] <= 4'h0;
                else if (reg_write && reg_addr == ENABLE_ADDR)
                    alarm_enable_q[ch] <= reg_wdata[3:0];
            end

            alarm_channel #(
                .ZERO_RUN_LONG(ZERO_RUN_LONG)
            ) u_alarm (
                .clk(clk),
                .reset_n(reset_n),
                .rx_bit_valid(rx_bit_valid[ch]),
                .rx_bit(rx_bit[ch]),
                .extended_loss_window(command_two_q[liu_regs_pkg::EXT_LOSS_BIT]),
                .driver_fault_in(alarm_sync_q[ch]),
                .code_violation_in(alarm_sync_q[NUM_CH + ch]),
                .tx_clock_missing_in(alarm_sync_q[2*NUM_CH + ch]),
                .status_read(status_read[ch]),
                .alarm_enable(alarm_enable_q[ch]),
                .status(status[ch]),
                .signal_loss(signal_loss[ch]),
                .irq_pending(pending[ch])
            );

            // Muting is combinational so the first bit after loss is already low
            assign rx_data_out[ch] = rx_data_in[ch]
                && !(command_two_q[liu_regs_pkg::RX_SQUELCH_BIT] && signal_loss[ch]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered; read data appears the cycle after the strobe
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_addr == liu_regs_pkg::GLOBAL_COMMAND_ONE_ADDR)
            rdata_d = command_one_q;
        else if (reg_addr == liu_regs_pkg::GLOBAL_COMMAND_TWO_ADDR)
            rdata_d = command_two_q;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (reg_addr == liu_regs_pkg::CHANNEL0_ALARM_STATUS_ADDR
                + 4'(i) * liu_regs_pkg::CHANNEL_STRIDE)
                rdata_d = status[i];
            if (reg_addr == liu_regs_pkg::ALARM_ENABLE_BASE_ADDR
                + 4'(i) * liu_regs_pkg::CHANNEL_STRIDE)
                rdata_d = {4'h0, alarm_enable_q[i]};
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= rdata_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt: level, held while global enable is set and any enabled change is latched
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_q <= 1'b0;
        else
            irq_q <= command_one_q[liu_regs_pkg::GLOBAL_IRQ_BIT] && |pending;
    end

    assign irq_out = 1'b0;
    assign irq_oe_n = !irq_q;
endmodule : e1_liu_config_status_regs
`default_nettype wire

// ===== dv/liu_regs_monitor.sv
// Port-level assertions for the line-interface register bank
`default_nettype none
module liu_regs_monitor #(
    parameter int ZERO_RUN_LONG = 4096,
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Line and alarm side
    input wire logic board_test_n,
    input wire logic [NUM_CH-1:0] rx_bit_valid,
    input wire logic [NUM_CH-1:0] rx_bit,
    input wire logic [NUM_CH-1:0] driver_fault_in,
    input wire logic [NUM_CH-1:0] code_violation_in,
    input wire logic [NUM_CH-1:0] tx_clock_missing_in,
    input wire logic [NUM_CH-1:0] rx_data_in,
    input wire logic [NUM_CH-1:0] rx_data_out,
    // Controls and interrupt
    input wire liu_regs_pkg::datapath_ctrl_t datapath_ctrl,
    input wire logic outputs_float_n,
    input wire logic irq_out,
    input wire logic irq_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic gie_q;
    // Shadow of the global enable, since it is not visible at the ports
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            gie_q <= 1'b0;
        else if (reg_write && reg_addr == 4'h0)
            gie_q <= reg_wdata[1];
    chk_fifo_depth_set: assert property (reg_write && reg_addr == 4'h1 |=>
        datapath_ctrl.fifo_depth == ($past(reg_wdata[5]) ? 7'h40 : 7'h20))
        else $error("fifo depth does not follow write");
    chk_atten_place_set: assert property (reg_write && reg_addr == 4'h1 |=>
        datapath_ctrl.ja_place == ($past(reg_wdata[4:3]) == 2'h1 ? liu_regs_pkg::JA_TX :
        $past(reg_wdata[4:3]) == 2'h2 ? liu_regs_pkg::JA_RX : liu_regs_pkg::JA_OFF))
        else $error("attenuator placement wrong");
    chk_low_bits_set: assert property (reg_write && reg_addr == 4'h1 |=>
        datapath_ctrl[2:0] == $past(reg_wdata[2:0]))
        else $error("control bits do not follow write");
    chk_mute_pass: assert property (!datapath_ctrl.rx_squelch_on_signal_loss |->
        rx_data_out == rx_data_in)
        else $error("receive data altered without muting");
    chk_mute_only_low: assert property ((rx_data_out & ~rx_data_in) == '0)
        else $error("muted data driven high");
    chk_soft_float: assert property (datapath_ctrl.board_test_tristate |->
        !outputs_float_n)
        else $error("software test bit does not float outputs");
    chk_pin_float: assert property (!board_test_n [*4] |-> !outputs_float_n)
        else $error("test pin does not float outputs");
    chk_unmapped_zero: assert property (reg_read &&
        reg_addr inside {4'h4, 4'h7, 4'ha, 4'hd, 4'he, 4'hf} |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    chk_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data changed without read");
    chk_live_driver: assert property ($stable(driver_fault_in[0]) [*5] ##0
        (reg_read && reg_addr == 4'h2) |=> reg_rdata[7] == $past(driver_fault_in[0]))
        else $error("live driver fault bit wrong");
    chk_irq_masked: assert property (!gie_q [*2] |-> irq_oe_n)
        else $error("interrupt without global enable");
    chk_irq_open_drain: assert property (irq_out == 1'b0)
        else $error("interrupt data not low");
endmodule : liu_regs_monitor
////////////////////////////////////////////////////////////////
bind e1_liu_config_status_regs liu_regs_monitor #(.ZERO_RUN_LONG(ZERO_RUN_LONG),
    .NUM_CH(NUM_CH)) u_monitor (.clk, .reset_n, .reg_addr, .reg_write, .reg_read,
    .reg_wdata, .reg_rdata, .board_test_n, .rx_bit_valid, .rx_bit, .driver_fault_in,
    .code_violation_in, .tx_clock_missing_in, .rx_data_in, .rx_data_out,
    .datapath_ctrl, .outputs_float_n, .irq_out, .irq_oe_n);
`default_nettype wire

// ===== dv/host_model.sv
// Host processor model driving the parallel register port
`default_nettype none
module host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [3:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        reg_addr = 4'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= (a == 4'h1) ? (d & 8'h3f) : d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : host_model
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the line-interface register bank
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int ZRUN = 16;
    typedef struct packed {
        logic [7:0] w;
        logic [6:0] depth;
        liu_regs_pkg::ja_place_t ja;
    } row_t;
    row_t rows [7] = '{'{8'h00, 7'h20, liu_regs_pkg::JA_OFF},
        '{8'h20, 7'h40, liu_regs_pkg::JA_OFF}, '{8'h08, 7'h20, liu_regs_pkg::JA_TX},
        '{8'h10, 7'h20, liu_regs_pkg::JA_RX}, '{8'h18, 7'h20, liu_regs_pkg::JA_OFF},
        '{8'h3f, 7'h40, liu_regs_pkg::JA_OFF}, '{8'h07, 7'h20, liu_regs_pkg::JA_OFF}};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] rd_val;
    logic board_test_n = 1'b1;
    logic [3:0] rx_bit_valid = 4'h0;
    logic [3:0] rx_bit = 4'h0;
    logic [3:0] driver_fault_in = 4'h0;
    logic [3:0] code_violation_in = 4'h0;
    logic [3:0] tx_clock_missing_in = 4'h0;
    logic [3:0] rx_data_in = 4'hf;
    logic [3:0] rx_data_out;
    liu_regs_pkg::datapath_ctrl_t datapath_ctrl;
    logic outputs_float_n;
    logic irq_out;
    logic irq_oe_n;
    int failures = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    host_model host (.clk, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata);
    e1_liu_config_status_regs #(.ZERO_RUN_LONG(ZRUN)) dut (.clk, .reset_n, .reg_addr,
        .reg_write, .reg_read, .reg_wdata, .reg_rdata, .board_test_n, .rx_bit_valid,
        .rx_bit, .driver_fault_in, .code_violation_in, .tx_clock_missing_in,
        .rx_data_in, .rx_data_out, .datapath_ctrl, .outputs_float_n, .irq_out, .irq_oe_n);
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        host.rd(a, rd_val);
        chk(rd_val, exp);
    endtask : rdchk
    // Bound of ten cycles covers the sync and register lag with margin
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq_oe_n !== lvl && n < 10)
        begin
            // Look mid-cycle so the registered interrupt has settled
            @(negedge clk);
            n++;
        end
        chk({7'h00, irq_oe_n}, {7'h00, lvl});
        if (n == 10 && irq_oe_n !== lvl)
            complete_run();
    endtask : wait_irq
    task automatic send_bits(input int n, input logic b);
        repeat (n)
        begin
            @(posedge clk);
            rx_bit_valid[2] <= 1'b1;
            rx_bit[2] <= b;
        end
        @(posedge clk);
        rx_bit_valid[2] <= 1'b0;
        rx_bit[2] <= ~b;
    endtask : send_bits
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 16; a++)
            rdchk(4'(a), 8'h00);
        foreach (rows[i])
        begin
            host.wr(4'h1, rows[i].w);
            @(negedge clk);
            chk({1'b0, datapath_ctrl.fifo_depth}, {1'b0, rows[i].depth});
            chk({6'h00, datapath_ctrl.ja_place}, {6'h00, rows[i].ja});
            chk({5'h00, datapath_ctrl[2:0]}, {5'h00, rows[i].w[2:0]});
            rdchk(4'h1, rows[i].w);
        end
        host.wr(4'h1, 8'h06);
        send_bits(ZRUN - 1, 1'b0);
        repeat (3) @(posedge clk);
        rdchk(4'h8, 8'h00);
        send_bits(1, 1'b0);
        repeat (3) @(posedge clk);
        rdchk(4'h8, 8'h44);
        chk({4'h0, rx_data_out}, 8'h0b);
        send_bits(1, 1'b1);
        repeat (3) @(posedge clk);
        rdchk(4'h8, 8'h04);
        chk({4'h0, rx_data_out}, 8'h0f);
        // Normal window: loss only at the package's zero-run length
        host.wr(4'h1, 8'h04);
        send_bits(liu_regs_pkg::LOSS_ZEROS_NORMAL - 1, 1'b0);
        repeat (3) @(posedge clk);
        rdchk(4'h8, 8'h00);
        send_bits(1, 1'b0);
        repeat (3) @(posedge clk);
        rdchk(4'h8, 8'h44);
        chk({4'h0, rx_data_out}, 8'h0b);
        send_bits(1, 1'b1);
        repeat (3) @(posedge clk);
        rdchk(4'h8, 8'h04);
        host.wr(4'h1, 8'h00);
        driver_fault_in[1] <= 1'b1;
        driver_fault_in[0] <= 1'b1;
        repeat (5) @(posedge clk);
        rdchk(4'h5, 8'h88);
        rdchk(4'h5, 8'h80);
        rdchk(4'h2, 8'h88);
        driver_fault_in[1] <= 1'b0;
        code_violation_in[1] <= 1'b1;
        repeat (5) @(posedge clk);
        rdchk(4'h5, 8'h2a);
        host.wr(4'hc, 8'h01);
        tx_clock_missing_in[3] <= 1'b1;
        repeat (6) @(posedge clk);
        chk({7'h00, irq_oe_n}, 8'h01);
        host.wr(4'h0, 8'h02);
        wait_irq(1'b0);
        rdchk(4'hb, 8'h11);
        wait_irq(1'b1);
        code_violation_in[3] <= 1'b1;
        repeat (6) @(posedge clk);
        chk({7'h00, irq_oe_n}, 8'h01);
        chk({7'h00, irq_out}, 8'h00);
        board_test_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk({7'h00, outputs_float_n}, 8'h00);
        board_test_n <= 1'b1;
        host.wr(4'he, 8'ha5);
        rdchk(4'he, 8'h00);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
